// ---- rtl/timer8_pkg.sv ----
// package: register map, reset values, modes and state layout of the 8-bit compare timer
package timer8_pkg;
	// register byte addresses on the register bus
	localparam logic [7:0] OFS_CTRL   = 8'h00; // mode, clock, actions, pin control
	localparam logic [7:0] OFS_COUNT  = 8'h04; // timer_count_value
	localparam logic [7:0] OFS_CMP_A  = 8'h08; // compare_value_a
	localparam logic [7:0] OFS_CMP_B  = 8'h0C; // compare_value_b
	localparam logic [7:0] OFS_FLAGS  = 8'h10; // flags, write one to clear
	localparam logic [7:0] OFS_FORCE  = 8'h14; // force strobes (write), output states (read)
	// control register field positions
	localparam int WAVE_LSB   = 0;  // waveform_select, 3 bits
	localparam int CLKSEL_LSB = 3;  // clock_source_select, 3 bits
	localparam int ACT_A_LSB  = 6;  // compare_output_action a, 2 bits
	localparam int ACT_B_LSB  = 8;  // compare_output_action b, 2 bits
	localparam int DIR_A_BIT  = 10; // pin_direction_bit a
	localparam int DIR_B_BIT  = 11; // pin_direction_bit b
	localparam int PORT_A_BIT = 12; // general port output value a
	localparam int PORT_B_BIT = 13; // general port output value b
	// flag register bit positions
	localparam int OVF_BIT = 0;
	localparam int MFA_BIT = 1;
	localparam int MFB_BIT = 2;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_PRE  = 10'h000;
	// counter extremes
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	// waveform_select codes
	localparam logic [2:0] WAVE_NORMAL   = 3'h0;
	localparam logic [2:0] WAVE_CLEAR    = 3'h2; // clear_on_match_mode
	localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
	localparam logic [2:0] WAVE_FAST_CMP = 3'h7;
	// clock_source_select codes: stop, /1, /8, /64, /256, /1024
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_D1   = 3'h1;
	localparam logic [2:0] CLK_D8   = 3'h2;
	localparam logic [2:0] CLK_D64  = 3'h3;
	localparam logic [2:0] CLK_D256 = 3'h4;
	localparam logic [2:0] CLK_D1K  = 3'h5;
	// compare_output_action codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOG  = 2'h1;
	localparam logic [1:0] ACT_CLR  = 2'h2;
	localparam logic [1:0] ACT_SET  = 2'h3;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// whole state of the timer block
	typedef struct packed {
		logic [13:0] ctrl;   // control register
		logic [7:0]  cnt;    // timer_count_value
		logic [7:0]  cmp_a;  // active compare a
		logic [7:0]  cmp_b;  // active compare b
		logic [7:0]  buf_a;  // cpu side compare a
		logic [7:0]  buf_b;  // cpu side compare b
		logic        ovf;    // overflow_flag
		logic        mfa;    // match_flag_a
		logic        mfb;    // match_flag_b
		logic        oc_a;   // compare_output_state a
		logic        oc_b;   // compare_output_state b
		logic        block;  // matches held off through the next tick
		logic [9:0]  pre;    // prescaler count
		logic        aw_got; // write address held
		logic [7:0]  aw_adr;
		logic        w_got;  // write data held
		logic [31:0] w_dat;
		logic [3:0]  w_stb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} timer_state_t;

	// pin drive pair for one compare pin
	typedef struct packed {
		logic out; // level driven
		logic oe;  // high while driving
	} pin_drive_t;
endpackage

// ---- rtl/timer8_compare.sv ----
// 8-bit timer with two compare channels, waveform modes and an AXI4-Lite register slave
// Overview of operation
// (RQ1) cpu compare access hits buffer or register
// (RQ2) force strobe updates output, no flag/clear
// (RQ3) count write blocks matches next timer tick
// (RQ4) action change applies from next match
// (RQ5) reset clears both compare output states
// (RQ6) nonzero action overrides port value, direction kept
// (RQ7) output state survives mode changes
// (RQ8) action zero leaves output state unchanged
// (RQ9) count sequence from mode only
// (RQ10) mode 0 counts up, wraps FF to 00
// (RQ11) normal mode overflow set when count zero
// (RQ12) mode 2 clears counter at compare a
// (RQ13) unbuffered compare a may miss, wraps
// (RQ14) match flag a each top in mode 2
// (RQ15) mode 2 action 1 toggles on match
// (RQ16) mode 2 overflow on max to zero
// (RQ17) modes 3/7 count zero to top, restart
// (RQ18) fast pwm match and bottom set/clear output
// (RQ19) fast pwm clears counter tick after top
// (RQ20) fast pwm overflow set at top
// (RQ21) prescale 1, 8, 64, 256, 1024
// (RQ22) compare buffered in pwm, loaded at top
// (RQ23) match flag set next tick, write-one clears
// (RQ24) cpu count write beats clear and count
// (RQ25) clock select zero stops, count still accessible
// (RQ26) single clock, timer tick is enable
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module timer8_compare
	import timer8_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output pin_drive_t       pin_a,
	output pin_drive_t       pin_b
);
	timer_state_t s;       // registered state
	timer_state_t n;       // next state
	logic [2:0]   wave;    // waveform_select
	logic [2:0]   clksel;  // clock_source_select
	logic [1:0]   act_a;   // compare_output_action a
	logic [1:0]   act_b;   // compare_output_action b
	logic         tick;    // one-cycle timer clock enable
	logic         pwm;     // fast pwm mode active
	logic [7:0]   top;     // top of the count
	logic         at_top;  // counter sits on top this tick
	logic         clr_cnt; // counter returns to bottom this tick
	logic         match_a; // qualified compare match a
	logic         match_b; // qualified compare match b
	logic         ovf_ev;  // overflow event
	logic         wr_go;   // register write performed this cycle
	logic         cnt_wr;  // cpu write to the count
	logic         ctrl_wr; // cpu write to the control register
	logic         force_a; // force strobe a
	logic         force_b; // force strobe b

	// next output state of one channel; pwm ignores force strobes
	function automatic logic next_oc(input logic oc, input logic [1:0] act, input logic in_pwm,
		input logic tog_ok, input logic hit, input logic frc, input logic bottom);
		logic r;
		r = oc;
		if (!in_pwm) begin
			// non-pwm: set, clear or toggle on match or force; action zero holds [RQ2] [RQ8]
			if (hit || frc) begin
				unique case (act)
					ACT_TOG: r = ~oc; // [RQ15]
					ACT_CLR: r = 1'b0;
					ACT_SET: r = 1'b1;
					default: r = oc;
				endcase
			end
		end else begin
			// pwm: match first, then bottom wins so compare at top gives a steady level [RQ18]
			if (hit) begin
				if (act == ACT_CLR)
					r = 1'b0;
				else if (act == ACT_SET)
					r = 1'b1;
				else if (act == ACT_TOG && tog_ok)
					r = ~oc;
			end
			if (bottom) begin
				if (act == ACT_CLR)
					r = 1'b1;
				else if (act == ACT_SET)
					r = 1'b0;
			end
		end
		return r;
	endfunction

	// control field decode
	assign wave   = s.ctrl[WAVE_LSB +: 3];
	assign clksel = s.ctrl[CLKSEL_LSB +: 3];
	assign act_a  = s.ctrl[ACT_A_LSB +: 2];
	assign act_b  = s.ctrl[ACT_B_LSB +: 2];

	// prescaler taps; the free-running count makes the first tick after a select change
	// arrive early, traded for a single shared divider [RQ21] [RQ25] [RQ26]
	always_comb begin
		unique case (clksel)
			CLK_D1:   tick = 1'b1;
			CLK_D8:   tick = (s.pre[2:0] == 3'h0);
			CLK_D64:  tick = (s.pre[5:0] == 6'h00);
			CLK_D256: tick = (s.pre[7:0] == 8'h00);
			CLK_D1K:  tick = (s.pre == RST_PRE);
			default:  tick = 1'b0; // stopped; external sources not wired
		endcase
	end

	// counting sequence from waveform_select only [RQ9] [RQ17]
	assign pwm     = (wave == WAVE_FAST_MAX) || (wave == WAVE_FAST_CMP);
	assign top     = (wave == WAVE_FAST_CMP) ? s.cmp_a : CNT_MAX;
	assign at_top  = tick && (s.cnt == top);
	assign clr_cnt = (tick && wave == WAVE_CLEAR && s.cnt == s.cmp_a) || (pwm && at_top); // [RQ12] [RQ19]
	// matches are suppressed from a count write through the next tick [RQ3]
	assign match_a = tick && !s.block && (s.cnt == s.cmp_a);
	assign match_b = tick && !s.block && (s.cnt == s.cmp_b);
	// overflow: at top in fast pwm, otherwise on max to zero [RQ11] [RQ16] [RQ20]
	assign ovf_ev  = pwm ? at_top : (tick && s.cnt == CNT_MAX);

	// register write decode, done once address and data are both held
	assign wr_go   = s.aw_got && s.w_got && !s.bvalid;
	assign cnt_wr  = wr_go && s.aw_adr == OFS_COUNT && s.w_stb[0];
	assign ctrl_wr = wr_go && s.aw_adr == OFS_CTRL;
	assign force_a = wr_go && s.aw_adr == OFS_FORCE && s.w_stb[0] && s.w_dat[0];
	assign force_b = wr_go && s.aw_adr == OFS_FORCE && s.w_stb[0] && s.w_dat[1];

	// bus handshakes: one write and one read outstanding
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready  = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	// pins: nonzero action hands the pin to the compare state, direction stays with software [RQ6]
	assign pin_a.out = (act_a != ACT_NONE) ? s.oc_a : s.ctrl[PORT_A_BIT];
	assign pin_a.oe  = s.ctrl[DIR_A_BIT];
	assign pin_b.out = (act_b != ACT_NONE) ? s.oc_b : s.ctrl[PORT_B_BIT];
	assign pin_b.oe  = s.ctrl[DIR_B_BIT];

	// next-state logic for timer and bus
	always_comb begin
		n = s;
		n.pre = s.pre + 10'h001;
		// counter steps on tick only; holds when stopped [RQ10] [RQ25]
		if (tick)
			n.cnt = clr_cnt ? CNT_BOTTOM : 8'(s.cnt + 8'h01);
		// block lasts up to the next tick
		if (tick)
			n.block = 1'b0;
		// buffered compare loads at top in pwm [RQ22]
		if (pwm && at_top) begin
			n.cmp_a = s.buf_a;
			n.cmp_b = s.buf_b;
		end
		// output state; mode changes never touch it [RQ4] [RQ7]
		n.oc_a = next_oc(s.oc_a, act_a, pwm, wave == WAVE_FAST_CMP, match_a, force_a, pwm && at_top);
		n.oc_b = next_oc(s.oc_b, act_b, pwm, 1'b0, match_b, force_b, pwm && at_top);
		// flags: set beats a write-one clear in the same cycle [RQ14] [RQ23]
		n.ovf = s.ovf | ovf_ev;
		n.mfa = s.mfa | match_a;
		n.mfb = s.mfb | match_b;
		// write channels taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.aw_adr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.w_dat = s_axi_wdata;
			n.w_stb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		// perform the write and answer
		if (wr_go) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			unique case (s.aw_adr)
				OFS_CTRL: begin
					if (s.w_stb[0])
						n.ctrl[7:0] = s.w_dat[7:0];
					if (s.w_stb[1])
						n.ctrl[13:8] = s.w_dat[13:8];
				end
				OFS_COUNT: begin
					// cpu write beats clear and count, and arms the block [RQ3] [RQ24]
					if (s.w_stb[0]) begin
						n.cnt   = s.w_dat[7:0];
						n.block = 1'b1;
					end
				end
				OFS_CMP_A: begin
					// buffered in pwm, direct otherwise [RQ1] [RQ13] [RQ22]
					if (s.w_stb[0]) begin
						n.buf_a = s.w_dat[7:0];
						if (!pwm)
							n.cmp_a = s.w_dat[7:0];
					end
				end
				OFS_CMP_B: begin
					if (s.w_stb[0]) begin
						n.buf_b = s.w_dat[7:0];
						if (!pwm)
							n.cmp_b = s.w_dat[7:0];
					end
				end
				OFS_FLAGS: begin
					// write one clears, unless hardware sets in this cycle
					if (s.w_stb[0]) begin
						n.ovf = (s.ovf & ~s.w_dat[OVF_BIT]) | ovf_ev;
						n.mfa = (s.mfa & ~s.w_dat[MFA_BIT]) | match_a;
						n.mfb = (s.mfb & ~s.w_dat[MFB_BIT]) | match_b;
					end
				end
				OFS_FORCE: n.bresp = RESP_OKAY; // strobes act through force_a/force_b
				default:   n.bresp = RESP_SLVERR;
			endcase
		end
		// read channel: answer in the cycle after the address is taken
		if (s.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			unique case ({s_axi_araddr[7:2], 2'b00})
				OFS_CTRL:  n.rdata = {18'h00000, s.ctrl};
				OFS_COUNT: n.rdata = {24'h000000, s.cnt};
				OFS_CMP_A: n.rdata = {24'h000000, s.buf_a}; // [RQ1]
				OFS_CMP_B: n.rdata = {24'h000000, s.buf_b};
				OFS_FLAGS: n.rdata = {29'h00000000, s.mfb, s.mfa, s.ovf};
				OFS_FORCE: n.rdata = {30'h00000000, s.oc_b, s.oc_a};
				default:   n.rresp = RESP_SLVERR;
			endcase
		end
	end

	// state register; synchronous reset clears output states too [RQ5]
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s <= '0;
		else
			s <= n;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_normal_wrap;
		(wave == WAVE_NORMAL && tick && s.cnt == CNT_MAX && !cnt_wr) |=> (s.cnt == CNT_BOTTOM && s.ovf);
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode did not wrap with overflow"); // [RQ10]
	property p_block;
		(s.block && tick && s.cnt == s.cmp_a && !s.mfa) |=> !s.mfa;
	endproperty
	a_block: assert property (p_block) else $error("match seen after count write"); // [RQ3]
	property p_block_arm;
		cnt_wr |=> s.block;
	endproperty
	a_block_arm: assert property (p_block_arm) else $error("count write did not arm block"); // [RQ3]
	property p_ctc_clear;
		(wave == WAVE_CLEAR && tick && !s.block && s.cnt == s.cmp_a && !cnt_wr) |=> (s.cnt == CNT_BOTTOM && s.mfa);
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match did not clear"); // [RQ12]
	property p_pwm_top;
		(pwm && at_top && !cnt_wr) |=> (s.cnt == CNT_BOTTOM && s.ovf);
	endproperty
	a_pwm_top: assert property (p_pwm_top) else $error("fast pwm top not handled"); // [RQ19]
	property p_force_noflag;
		(force_a && !match_a && !s.mfa) |=> !s.mfa;
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("force set a match flag"); // [RQ2]
	property p_act_zero;
		(act_a == ACT_NONE) |=> (s.oc_a == $past(s.oc_a));
	endproperty
	a_act_zero: assert property (p_act_zero) else $error("action zero changed output"); // [RQ8]
	property p_override;
		(act_b != ACT_NONE) |-> (pin_b.out == s.oc_b && pin_b.oe == s.ctrl[DIR_B_BIT]);
	endproperty
	a_override: assert property (p_override) else $error("pin b not driven by compare state"); // [RQ6]
	property p_stopped;
		(clksel == CLK_STOP && !cnt_wr) |=> (s.cnt == $past(s.cnt));
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // [RQ25]
	property p_buffered;
		(pwm && !at_top && wr_go && s.aw_adr == OFS_CMP_A) |=> (s.cmp_a == $past(s.cmp_a));
	endproperty
	a_buffered: assert property (p_buffered) else $error("pwm compare not buffered"); // [RQ22]
	property p_div8;
		(clksel == CLK_D8 && tick && !ctrl_wr) |=> !tick;
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 ticked twice"); // [RQ21]
	// force outside pwm sets the state when the action says set
	property p_force_set;
		(!pwm && force_a && act_a == ACT_SET) |=> s.oc_a;
	endproperty
	a_force_set: assert property (p_force_set) else $error("force did not set output a"); // [RQ2]
	// toggle in clear-on-match flips the state on every match
	property p_ctc_toggle;
		(wave == WAVE_CLEAR && act_a == ACT_TOG && match_a) |=> (s.oc_a != $past(s.oc_a));
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("clear-on-match toggle missed"); // [RQ15]
	// clear-on-match still flags overflow when the count rolls over from max
	property p_ctc_ovf;
		(wave == WAVE_CLEAR && tick && s.cnt == CNT_MAX && !cnt_wr) |=> (s.cnt == CNT_BOTTOM && s.ovf);
	endproperty
	a_ctc_ovf: assert property (p_ctc_ovf) else $error("clear-on-match overflow missed"); // [RQ16]
	// hardware never clears overflow; only a flag write may
	property p_ovf_hold;
		(s.ovf && !(wr_go && s.aw_adr == OFS_FLAGS)) |=> s.ovf;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped by itself"); // [RQ11]
	// non-inverted pwm goes low on a match away from bottom
	property p_pwm_match;
		(pwm && match_a && !at_top && act_a == ACT_CLR) |=> !s.oc_a;
	endproperty
	a_pwm_match: assert property (p_pwm_match) else $error("pwm match did not clear output a"); // [RQ18]
	// bottom of a pwm period restores the idle level of the polarity
	property p_pwm_bottom;
		(pwm && at_top && act_a[1]) |=> (s.oc_a != $past(act_a[0]));
	endproperty
	a_pwm_bottom: assert property (p_pwm_bottom) else $error("pwm bottom level wrong"); // [RQ18]
	// active compare picks up the buffer when the period ends
	property p_pwm_load;
		(pwm && at_top) |=> (s.cmp_a == $past(s.buf_a));
	endproperty
	a_pwm_load: assert property (p_pwm_load) else $error("pwm compare not loaded at top"); // [RQ22]
	// outside pwm a compare write lands in the active register at once
	property p_cmp_direct;
		(!pwm && wr_go && s.aw_adr == OFS_CMP_A && s.w_stb[0]) |=> (s.cmp_a == $past(s.w_dat[7:0]));
	endproperty
	a_cmp_direct: assert property (p_cmp_direct) else $error("compare a write did not land"); // [RQ1]
	// a match raises its flag on the next edge
	property p_flag_set;
		match_b |=> s.mfb;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("match b flag not set"); // [RQ23]
	// write one clears the flag when no match comes with it
	property p_flag_clear;
		(wr_go && s.aw_adr == OFS_FLAGS && s.w_stb[0] && s.w_dat[MFB_BIT] && !match_b) |=> !s.mfb;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("match b flag not cleared"); // [RQ23]
	// a control write alone leaves the output state where it was
	property p_mode_keep;
		(ctrl_wr && !match_a && !force_a && !(pwm && at_top)) |=> (s.oc_a == $past(s.oc_a));
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode change moved output a"); // [RQ7]
endmodule

// ---- rtl/_unused_placeholder_removed.sv ----
// empty file intentionally holding only this comment

// ---- testbench/timer8_compare_waveform_modes_tb_top.sv ----
// testbench: register bus tasks and scenarios for the 8-bit compare timer
`timescale 1ns/100ps
module timer8_compare_waveform_modes_tb_top
	import timer8_pkg::*;
;
	logic        aclk;      // 20 MHz bus and timer clock
	logic        aresetn;   // synchronous reset, active low
	logic        awvalid;   // write address channel
	logic        awready;
	logic [7:0]  awaddr;
	logic        wvalid;    // write data channel
	logic        wready;
	logic [31:0] wdata;
	logic        bvalid;    // write response channel
	logic        bready;
	logic [1:0]  bresp;
	logic        arvalid;   // read address channel
	logic        arready;
	logic [7:0]  araddr;
	logic        rvalid;    // read data channel
	logic        rready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	pin_drive_t  pin_a;     // compare pin a drive pair
	pin_drive_t  pin_b;     // compare pin b drive pair
	logic [1:0]  resp;      // last response code seen
	logic [31:0] v;         // scratch read value
	logic [31:0] c;         // scratch count value
	int          error_cnt; // mismatches seen
	int          tests_run; // comparisons made
	logic [2:0]  sel [2];   // prescaler selects under test
	int          dv [2];    // matching division factors
	logic [1:0]  act [2];   // pwm polarities under test

	timer8_compare dut_u (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_awaddr  (awaddr),
		.s_axi_awprot  (3'h0),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hF),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_bresp   (bresp),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_araddr  (araddr),
		.s_axi_arprot  (3'h0),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.pin_a         (pin_a),
		.pin_b         (pin_b)
	);

	// free running clock, period 50 ns
	always #25 aclk = ~aclk;

	// verdict and end of run, reached from the main sequence or a stuck wait
	task tally_and_finish;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one comparison, counted, reported at once on mismatch
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a wait that ran out of its bound counts as a mismatch and ends the run
	task stuck;
		chk(32'h0, 32'h1);
		tally_and_finish;
	endtask

	// bus write: address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) stuck();
		resp = bresp;
		bready <= 1'b0;
	endtask

	// bus read: rready held high until the data is seen
	task rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) stuck();
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// read and compare in one call
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask

	// control word: pins is {port b, port a, dir b, dir a}
	function automatic logic [31:0] mk(input logic [2:0] w, input logic [2:0] cs, input logic [1:0] a,
			input logic [1:0] b, input logic [3:0] pins);
		return {18'h0, pins, b, a, cs, w};
	endfunction

	// run the timer at full rate for n cycles, then stop it and read the count
	task run(input logic [2:0] w, input logic [1:0] a, input int n);
		wr(OFS_CTRL, mk(w, CLK_D1, a, ACT_NONE, 4'h0));
		repeat (n) @(posedge aclk);
		wr(OFS_CTRL, mk(w, CLK_STOP, a, ACT_NONE, 4'h0));
		rd(OFS_COUNT, c);
	endtask

	// main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		error_cnt = 0;
		tests_run = 0;
		sel = '{CLK_D8, CLK_D64};
		dv = '{8, 64};
		act = '{ACT_CLR, ACT_SET};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_FORCE, 32'h0);
		chk(32'({pin_a, pin_b}), 32'h0);
		rchk(8'h3C, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(8'h3C, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR));
		// action overrides port a, port b still follows its port bit
		wr(OFS_CTRL, mk(WAVE_NORMAL, CLK_STOP, ACT_SET, ACT_NONE, 4'h7));
		chk(32'({pin_a, pin_b}), 32'h5);
		wr(OFS_FORCE, 32'h3);
		rchk(OFS_FORCE, 32'h1);
		rchk(OFS_FLAGS, 32'h0);
		chk(32'({pin_a, pin_b}), 32'hD);
		// new actions act on the next forced match
		wr(OFS_CTRL, mk(WAVE_CLEAR, CLK_STOP, ACT_CLR, ACT_TOG, 4'h3));
		wr(OFS_FORCE, 32'h3);
		rchk(OFS_FORCE, 32'h2);
		chk(32'({pin_a, pin_b}), 32'h7);
		wr(OFS_CTRL, mk(WAVE_FAST_MAX, CLK_STOP, ACT_NONE, ACT_NONE, 4'h0));
		rchk(OFS_FORCE, 32'h2);
		// prescaler rates, small slack for an early first tick
		for (int i = 0; i < 2; i++) begin
			wr(OFS_COUNT, 32'h0);
			wr(OFS_CTRL, mk(WAVE_NORMAL, sel[i], ACT_NONE, ACT_NONE, 4'h0));
			repeat (640) @(posedge aclk);
			wr(OFS_CTRL, mk(WAVE_NORMAL, CLK_STOP, ACT_NONE, ACT_NONE, 4'h0));
			rd(OFS_COUNT, v);
			chk(32'(v + 2 >= 640 / dv[i] && v <= 640 / dv[i] + 2), 32'h1);
		end
		repeat (20) @(posedge aclk);
		rchk(OFS_COUNT, v);
		// count written equal to compare: the first match is held off
		wr(OFS_CMP_A, 32'h5);
		wr(OFS_COUNT, 32'h5);
		wr(OFS_FLAGS, 32'h7);
		run(WAVE_NORMAL, ACT_NONE, 20);
		rchk(OFS_FLAGS, 32'h0);
		// normal mode wraps and flags overflow and both matches
		wr(OFS_COUNT, 32'hF0);
		run(WAVE_NORMAL, ACT_NONE, 40);
		chk(32'(c < 32'h30), 32'h1);
		rchk(OFS_FLAGS, 32'h7);
		wr(OFS_FLAGS, 32'h7);
		rchk(OFS_FLAGS, 32'h0);
		// clear on match: count stays at or below compare a, no overflow
		wr(OFS_CMP_A, 32'h10);
		wr(OFS_COUNT, 32'h0);
		run(WAVE_CLEAR, ACT_TOG, 100);
		chk(32'(c <= 32'h10), 32'h1);
		rchk(OFS_FLAGS, 32'h6);
		// compare below the count: no match until the count wraps
		wr(OFS_FLAGS, 32'h7);
		wr(OFS_COUNT, 32'h20);
		run(WAVE_CLEAR, ACT_TOG, 100);
		chk(32'(c > 32'h20), 32'h1);
		rchk(OFS_FLAGS, 32'h0);
		// keep going: roll over from max, then clear at compare a again
		run(WAVE_CLEAR, ACT_TOG, 200);
		chk(32'(c <= 32'h10), 32'h1);
		rchk(OFS_FLAGS, 32'h7);
		// fast pwm to max, both polarities, output level follows count
		wr(OFS_CMP_A, 32'h80);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_FLAGS, 32'h7);
			run(WAVE_FAST_MAX, act[i], 400);
			rd(OFS_FORCE, v);
			chk(32'(v[0]), 32'((c <= 32'h80) ^ (act[i] == ACT_SET)));
			rd(OFS_FLAGS, v);
			chk(32'(v[0]), 32'h1);
		end
		// fast pwm to compare a: buffered value takes over at the top
		wr(OFS_CMP_A, 32'h20);
		rchk(OFS_CMP_A, 32'h20);
		wr(OFS_COUNT, 32'h0);
		run(WAVE_FAST_CMP, ACT_CLR, 300);
		chk(32'(c <= 32'h20), 32'h1);
		tally_and_finish;
	end
endmodule
